// ---- verilog/bbmi_top.v ----
// Notes on behaviour
// - Every bus word is read by all cards, including the sender itself.
// - Each message opens with a header naming its content type.
// - Arbitration runs in every card alike; no card decides alone.
// - Every header seen on the bus is compared with all filter entries.
// - A matching message is written whole into the receive queue of its entry while that queue has room; words that arrive when it is full are lost.
// - Reception always wins the SRAM port and never waits for anything.
// - Receive and transmit queues live in an external static RAM.
// - Priority is low, mean or high and is shown on the level lines.
// - Each card holds its own arbiter competing for its queues.
// - Data is driven onto the bus only after winning arbitration.
// - Messages move as a sequence of 16-bit words.
// - The header carries the content type and the data word count.
// - The data words follow the header on the bus.
// - The system reset line resets all cards on the same clock edge.
`timescale 1ns/1ps
`include "bbmi_defs.vh"

module bbmi_top (
    input wire ref_clk_i,
    input wire sys_rst_i,
    input wire [2:0] card_slot_i,
    input wire [15:0] bus_data_i,
    output reg [15:0] bus_data_o,
    output reg bus_data_oe_o,
    input wire bus_strb_i,
    output reg bus_strb_o,
    input wire bus_sof_i,
    output reg bus_sof_o,
    input wire bus_busy_i,
    output reg bus_busy_o,
    output reg bus_busy_oe_o,
    input wire [2:0] bus_lvl_i,
    output reg [2:0] bus_lvl_o,
    output reg [2:0] bus_lvl_oe_o,
    input wire [7:0] bus_slot_i,
    output reg [7:0] bus_slot_o,
    output reg [7:0] bus_slot_oe_o,
    input wire tune_we_i,
    input wire [3:0] tune_idx_i,
    input wire [7:0] tune_type_i,
    input wire tune_fifo_i,
    input wire tune_valid_i,
    input wire [1:0] tx_prio0_i,
    input wire [1:0] tx_prio1_i,
    input wire cpu_req_i,
    input wire cpu_wr_i,
    input wire cpu_sel_i,
    input wire [15:0] cpu_wdata_i,
    output reg cpu_ack_o,
    output reg cpu_err_o,
    output reg [15:0] cpu_rdata_o,
    output reg [11:0] sram_addr_o,
    output reg [15:0] sram_wdata_o,
    output reg sram_we_o,
    output reg sram_ce_o,
    input wire [15:0] sram_rdata_i,
    output reg [3:0] fifo_empty_o,
    output reg [3:0] fifo_full_o,
    output reg rx_drop_o
);

    localparam ST_IDLE = 2'b00;
    localparam ST_LVL = 2'b01;
    localparam ST_SLOT = 2'b10;
    localparam ST_TX = 2'b11;

    // ----
    // Pin synchroniser
    // ----
    // Only the second stage is read; the first stage feeds nothing else.
    reg [32:0] meta_reg;
    reg [32:0] sync_reg;
    wire [32:0] pin_in = {card_slot_i, bus_slot_i, bus_lvl_i, bus_busy_i, bus_sof_i,
                          bus_strb_i, bus_data_i};
    wire [15:0] s_data = sync_reg[15:0];
    wire s_strb = sync_reg[16];
    wire s_sof = sync_reg[17];
    wire s_busy = sync_reg[18];
    wire [2:0] s_lvl = sync_reg[21:19];
    wire [7:0] s_slot = sync_reg[29:22];
    wire [2:0] s_card = sync_reg[32:30];

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            meta_reg <= 33'h000000000;
            sync_reg <= 33'h000000000;
        end
        else
        begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    // ----
    // State
    // ----
    reg [1:0] state_reg;
    reg [3:0] tick_reg;
    reg cur_fifo_reg;
    reg [2:0] cur_lvl_reg;
    reg tx_hdr_reg;
    reg tx_infl_reg;
    reg tx_end_reg;
    reg [7:0] tx_left_reg;
    reg rx_pend_reg;
    reg rx_fifo_reg;
    reg [15:0] rx_data_reg;
    reg rx_on_reg;
    reg [7:0] rx_left_reg;
    reg cpu_busy_reg;
    reg [1:0] rd_tag_reg;
    reg [7:0] tune_type [0:15];
    reg tune_fifo [0:15];
    reg [15:0] tune_vld_reg;
    reg [10:0] wptr [0:3];
    reg [10:0] rptr [0:3];
    integer i;
    integer k;

    // ----
    // Queue status
    // ----
    // Queues 0 and 1 receive, queues 2 and 3 transmit.
    wire [3:0] empty;
    wire [3:0] full;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_stat
            assign empty[gi] = (wptr[gi] == rptr[gi]);
            assign full[gi] = (wptr[gi][`BBMI_PTR_MSB] != rptr[gi][`BBMI_PTR_MSB]) &&
                (wptr[gi][`BBMI_PTR_MSB-1:0] == rptr[gi][`BBMI_PTR_MSB-1:0]);
        end
    endgenerate

    // ----
    // Local queue choice and arbitration decisions
    // ----
    // Between the two local queues the higher priority goes first; a tie favours queue 0.
    wire pend0 = !empty[2] && (tx_prio0_i != `BBMI_PRIO_OFF);
    wire pend1 = !empty[3] && (tx_prio1_i != `BBMI_PRIO_OFF);
    wire pick1 = pend1 && (!pend0 || (tx_prio1_i > tx_prio0_i));
    wire [1:0] pick_prio = pick1 ? tx_prio1_i : tx_prio0_i;
    wire [2:0] pick_lvl = (pick_prio == `BBMI_PRIO_HIGH) ? `BBMI_LVL_HIGH :
                          (pick_prio == `BBMI_PRIO_MEAN) ? `BBMI_LVL_MEAN : `BBMI_LVL_LOW;
    wire [2:0] top_lvl = s_lvl[2] ? `BBMI_LVL_HIGH :
                         s_lvl[1] ? `BBMI_LVL_MEAN : `BBMI_LVL_LOW;
    wire win_lvl = (cur_lvl_reg == top_lvl);
    wire [7:0] own_bit = 8'h01 << s_card;
    wire [7:0] lower_bits = own_bit - 8'h01;
    // Every card sees the same slot lines, so all agree on one winner.
    wire win_slot = ((s_slot & lower_bits) == 8'h00) && ((s_slot & own_bit) != 8'h00);

    // ----
    // Header filter lookup
    // ----
    reg hit;
    reg hit_fifo;
    always @*
    begin
        hit = 1'b0;
        hit_fifo = 1'b0;
        for (i = `BBMI_TUNE_N - 1; i >= 0; i = i - 1)
        begin
            if (tune_vld_reg[i] && (tune_type[i] == s_data[`BBMI_TYPE_HI:`BBMI_TYPE_LO]))
            begin
                hit = 1'b1;
                hit_fifo = tune_fifo[i];
            end
        end
    end

    // ----
    // SRAM port arbitration
    // ----
    // Receive writes take the port first so reception never waits on the CPU.
    wire g_rx = rx_pend_reg;
    wire g_tx = !g_rx && (state_reg == ST_TX) && !tx_infl_reg && !tx_end_reg &&
                !empty[{`BBMI_TX_REGION, cur_fifo_reg}];
    wire g_cpu = !g_rx && !g_tx && cpu_req_i && !cpu_busy_reg;
    reg [1:0] acc_idx;
    reg acc_we;
    reg [15:0] acc_data;
    reg acc_go;
    reg [10:0] acc_ptr;
    always @*
    begin
        acc_idx = {`BBMI_TX_REGION, cur_fifo_reg};
        acc_we = 1'b0;
        acc_data = cpu_wdata_i;
        acc_go = 1'b0;
        if (g_rx)
        begin
            acc_idx = {`BBMI_RX_REGION, rx_fifo_reg};
            acc_we = 1'b1;
            acc_data = rx_data_reg;
            acc_go = !full[acc_idx];
        end
        else if (g_tx)
        begin
            acc_go = 1'b1;
        end
        else if (g_cpu)
        begin
            acc_idx = {cpu_wr_i, cpu_sel_i};
            acc_we = cpu_wr_i;
            acc_go = cpu_wr_i ? !full[acc_idx] : !empty[acc_idx];
        end
        acc_ptr = acc_we ? wptr[acc_idx] : rptr[acc_idx];
    end

    // ----
    // Filter table, queue pointers and SRAM outputs
    // ----
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            tune_vld_reg <= 16'h0000;
            for (k = 0; k < 4; k = k + 1)
            begin
                wptr[k] <= `BBMI_PTR_RST;
                rptr[k] <= `BBMI_PTR_RST;
            end
            sram_addr_o <= 12'h000;
            sram_wdata_o <= 16'h0000;
            sram_we_o <= 1'b0;
            sram_ce_o <= 1'b0;
            fifo_empty_o <= 4'hF;
            fifo_full_o <= 4'h0;
            rx_drop_o <= 1'b0;
        end
        else
        begin
            if (tune_we_i)
            begin
                tune_vld_reg[tune_idx_i] <= tune_valid_i;
            end
            // Write and read pointers give first-in, first-out order.
            if (acc_go && acc_we)
            begin
                wptr[acc_idx] <= wptr[acc_idx] + `BBMI_PTR_INC;
            end
            else if (acc_go)
            begin
                rptr[acc_idx] <= rptr[acc_idx] + `BBMI_PTR_INC;
            end
            sram_ce_o <= acc_go;
            sram_we_o <= acc_go && acc_we;
            sram_addr_o <= {acc_idx, acc_ptr[`BBMI_PTR_MSB-1:0]};
            sram_wdata_o <= acc_data;
            fifo_empty_o <= empty;
            fifo_full_o <= full;
            // A full receive queue loses the word; software sees the pulse.
            rx_drop_o <= g_rx && full[{`BBMI_RX_REGION, rx_fifo_reg}];
        end
    end

    // Filter entries hold no reset value; the valid bits guard them.
    always @(posedge ref_clk_i)
    begin
        if (tune_we_i)
        begin
            tune_type[tune_idx_i] <= tune_type_i;
            tune_fifo[tune_idx_i] <= tune_fifo_i;
        end
    end

    // ----
    // Receive, arbitration, transmit and CPU answer
    // ----
    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= ST_IDLE;
            tick_reg <= `BBMI_PH_START;
            cur_fifo_reg <= 1'b0;
            cur_lvl_reg <= 3'b000;
            tx_hdr_reg <= 1'b0;
            tx_infl_reg <= 1'b0;
            tx_end_reg <= 1'b0;
            tx_left_reg <= `BBMI_LEN_ZERO;
            rx_pend_reg <= 1'b0;
            rx_fifo_reg <= 1'b0;
            rx_data_reg <= 16'h0000;
            rx_on_reg <= 1'b0;
            rx_left_reg <= `BBMI_LEN_ZERO;
            cpu_busy_reg <= 1'b0;
            rd_tag_reg <= `BBMI_TAG_NONE;
            bus_data_o <= 16'h0000;
            bus_data_oe_o <= 1'b0;
            bus_strb_o <= 1'b0;
            bus_sof_o <= 1'b0;
            bus_busy_o <= 1'b0;
            bus_busy_oe_o <= 1'b0;
            bus_lvl_o <= 3'b000;
            bus_lvl_oe_o <= 3'b000;
            bus_slot_o <= 8'h00;
            bus_slot_oe_o <= 8'h00;
            cpu_ack_o <= 1'b0;
            cpu_err_o <= 1'b0;
            cpu_rdata_o <= 16'h0000;
        end
        else
        begin
            // The common tick stays aligned in all cards because reset ends together.
            tick_reg <= tick_reg + `BBMI_TICK_INC;
            rx_pend_reg <= 1'b0;
            bus_strb_o <= 1'b0;
            bus_sof_o <= 1'b0;
            cpu_ack_o <= 1'b0;
            cpu_err_o <= 1'b0;

            // Every header on the bus, our own included, passes the filter.
            if (s_strb && s_sof)
            begin
                rx_on_reg <= hit;
                rx_pend_reg <= hit;
                rx_fifo_reg <= hit_fifo;
                rx_data_reg <= s_data;
                rx_left_reg <= s_data[`BBMI_LEN_HI:`BBMI_LEN_LO];
            end
            else if (s_strb && rx_on_reg && (rx_left_reg != `BBMI_LEN_ZERO))
            begin
                rx_pend_reg <= 1'b1;
                rx_data_reg <= s_data;
                rx_left_reg <= rx_left_reg - `BBMI_LEN_ONE;
            end

            rd_tag_reg <= !acc_go || acc_we ? `BBMI_TAG_NONE :
                          g_tx ? `BBMI_TAG_TX : `BBMI_TAG_CPU;

            // A CPU request is answered once; a refused one answers with an error.
            if (g_cpu)
            begin
                cpu_busy_reg <= 1'b1;
                if (!acc_go || acc_we)
                begin
                    cpu_ack_o <= 1'b1;
                    cpu_err_o <= !acc_go;
                end
            end
            else if (cpu_ack_o)
            begin
                cpu_busy_reg <= 1'b0;
            end
            if (rd_tag_reg == `BBMI_TAG_CPU)
            begin
                cpu_ack_o <= 1'b1;
                cpu_rdata_o <= sram_rdata_i;
            end

            case (state_reg)
                ST_IDLE:
                begin
                    // Rounds only start on the tick with the bus idle, so all cards join together.
                    if ((tick_reg == `BBMI_PH_START) && !s_busy && (pend0 || pend1))
                    begin
                        cur_fifo_reg <= pick1;
                        cur_lvl_reg <= pick_lvl;
                        bus_lvl_o <= pick_lvl;
                        bus_lvl_oe_o <= pick_lvl;
                        state_reg <= ST_LVL;
                    end
                end
                ST_LVL:
                begin
                    if (tick_reg == `BBMI_PH_LVL)
                    begin
                        bus_lvl_o <= 3'b000;
                        bus_lvl_oe_o <= 3'b000;
                        if (win_lvl)
                        begin
                            bus_slot_o <= own_bit;
                            bus_slot_oe_o <= own_bit;
                            state_reg <= ST_SLOT;
                        end
                        else
                        begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_SLOT:
                begin
                    if (tick_reg == `BBMI_PH_SLOT)
                    begin
                        bus_slot_o <= 8'h00;
                        bus_slot_oe_o <= 8'h00;
                        if (win_slot)
                        begin
                            bus_busy_o <= 1'b1;
                            bus_busy_oe_o <= 1'b1;
                            bus_data_oe_o <= 1'b1;
                            tx_hdr_reg <= 1'b1;
                            tx_infl_reg <= 1'b0;
                            state_reg <= ST_TX;
                        end
                        else
                        begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    // An empty queue mid-message holds the bus until the CPU refills it.
                    if (g_tx)
                    begin
                        tx_infl_reg <= 1'b1;
                    end
                    if (rd_tag_reg == `BBMI_TAG_TX)
                    begin
                        tx_infl_reg <= 1'b0;
                        bus_data_o <= sram_rdata_i;
                        bus_strb_o <= 1'b1;
                        bus_sof_o <= tx_hdr_reg;
                        tx_hdr_reg <= 1'b0;
                        if (tx_hdr_reg)
                        begin
                            tx_left_reg <= sram_rdata_i[`BBMI_LEN_HI:`BBMI_LEN_LO];
                            tx_end_reg <= (sram_rdata_i[`BBMI_LEN_HI:`BBMI_LEN_LO]
                                == `BBMI_LEN_ZERO);
                        end
                        else
                        begin
                            tx_left_reg <= tx_left_reg - `BBMI_LEN_ONE;
                            tx_end_reg <= (tx_left_reg == `BBMI_LEN_ONE);
                        end
                    end
                    // The last word stays driven for one cycle before the bus is freed.
                    if (tx_end_reg)
                    begin
                        tx_end_reg <= 1'b0;
                        bus_busy_o <= 1'b0;
                        bus_busy_oe_o <= 1'b0;
                        bus_data_oe_o <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

// ---- verilog/bbmi_defs.vh ----
`ifndef BBMI_DEFS_VH
`define BBMI_DEFS_VH

// Message words on the shared bus are 16 bits wide.
`define BBMI_WORD_W 16
// Header word layout: content type in the upper byte, data word count in the lower.
`define BBMI_TYPE_HI 15
`define BBMI_TYPE_LO 8
`define BBMI_LEN_HI 7
`define BBMI_LEN_LO 0
`define BBMI_LEN_ONE 8'h01
`define BBMI_LEN_ZERO 8'h00

// Header filter table and card slot count.
`define BBMI_TUNE_N 16
`define BBMI_SLOTS 8

// External SRAM: two region bits select the queue, ten bits address the word.
`define BBMI_ADDR_W 12
`define BBMI_PTR_W 11
`define BBMI_PTR_MSB 10
`define BBMI_PTR_INC 11'h001
`define BBMI_PTR_RST 11'h000
`define BBMI_RX_REGION 1'b0
`define BBMI_TX_REGION 1'b1

// Priority codes set per transmit queue; zero keeps the queue off the bus.
`define BBMI_PRIO_OFF 2'h0
`define BBMI_PRIO_LOW 2'h1
`define BBMI_PRIO_MEAN 2'h2
`define BBMI_PRIO_HIGH 2'h3
`define BBMI_LVL_LOW 3'b001
`define BBMI_LVL_MEAN 3'b010
`define BBMI_LVL_HIGH 3'b100

// Arbitration round timing on the common tick, in card clock cycles.
`define BBMI_TICK_W 4
`define BBMI_TICK_INC 4'h1
`define BBMI_PH_START 4'h0
`define BBMI_PH_LVL 4'h5
`define BBMI_PH_SLOT 4'hA

// Read tags for the SRAM return path.
`define BBMI_TAG_NONE 2'h0
`define BBMI_TAG_TX 2'h1
`define BBMI_TAG_CPU 2'h2

`endif

// ---- sim/bbmi_monitor.sv ----
`timescale 1ns/1ps
// ----
// Port checker for the bus interface.
// ----
module bbmi_monitor (
    input logic ref_clk_i,
    input logic sys_rst_i,
    input logic bus_strb_o,
    input logic bus_sof_o,
    input logic bus_data_oe_o,
    input logic bus_busy_o,
    input logic bus_busy_oe_o,
    input logic [2:0] bus_lvl_o,
    input logic [2:0] bus_lvl_oe_o,
    input logic [7:0] bus_slot_oe_o,
    input logic cpu_ack_o,
    input logic cpu_err_o,
    input logic sram_we_o,
    input logic sram_ce_o,
    input logic [3:0] fifo_empty_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // A transmitted message opens with a marked header word.
    sequence s_header;
        bus_strb_o && bus_sof_o;
    endsequence
    // Ownership starts when busy is raised after the slot phase.
    sequence s_arb_won;
        $rose(bus_busy_o);
    endsequence
    chk_reset_state: assert property (disable iff (1'b0)
        sys_rst_i |=> fifo_empty_o == 4'hF && !bus_data_oe_o && !cpu_ack_o)
        else $error("outputs not at reset values");
    chk_busy_pair: assert property (bus_busy_o |-> bus_busy_oe_o && bus_data_oe_o)
        else $error("busy driven without its enables");
    chk_strb_owned: assert property (bus_strb_o |-> bus_busy_o && bus_data_oe_o)
        else $error("word strobe without bus ownership");
    chk_strb_pulse: assert property (bus_strb_o |=> !bus_strb_o)
        else $error("word strobe longer than one cycle");
    chk_sof_strb: assert property (bus_sof_o |-> bus_strb_o)
        else $error("header marker without strobe");
    chk_level_onehot: assert property (|bus_lvl_oe_o |-> $onehot(bus_lvl_o & bus_lvl_oe_o))
        else $error("level lines not one-hot");
    chk_arb_phases: assert property (s_arb_won |->
        $past(bus_slot_oe_o) != 8'h00 && $past(bus_lvl_oe_o, 6) != 3'h0)
        else $error("bus taken without level and slot phases");
    chk_tx_header: assert property (s_arb_won |-> ##[1:16] s_header)
        else $error("no header word after winning the bus");
    chk_ack_pulse: assert property (cpu_ack_o |=> !cpu_ack_o && !cpu_err_o)
        else $error("acknowledge longer than one cycle");
    chk_sram_write: assert property (sram_we_o |-> sram_ce_o)
        else $error("memory write without chip enable");
endmodule

bind bbmi_top bbmi_monitor u_mon (.ref_clk_i, .sys_rst_i, .bus_strb_o, .bus_sof_o,
    .bus_data_oe_o, .bus_busy_o, .bus_busy_oe_o, .bus_lvl_o, .bus_lvl_oe_o,
    .bus_slot_oe_o, .cpu_ack_o, .cpu_err_o, .sram_we_o, .sram_ce_o, .fifo_empty_o);

// ---- sim/bbmi_peer.sv ----
`timescale 1ns/1ps
// ----
// Another master card in slot zero.
// ----
module bbmi_peer (
    input logic clk_i,
    input logic rst_i,
    input logic go_i,
    input logic [7:0] typ_i,
    input logic [7:0] len_i,
    input logic [2:0] lvl_i,
    input logic busy_w_i,
    input logic [2:0] lvl_w_i,
    output logic [15:0] data_o,
    output logic oe_o,
    output logic strb_o,
    output logic sof_o,
    output logic [2:0] lvl_o,
    output logic slot_o,
    output logic act_o
);
    logic [3:0] tick;
    logic [7:0] n;
    logic [1:0] ph;
    // Same tick grid as every card, so a shared reset keeps rounds aligned.
    always @(posedge clk_i)
    begin
        strb_o <= 1'b0;
        sof_o <= 1'b0;
        if (rst_i)
        begin
            tick <= 4'h0;
            act_o <= 1'b0;
            lvl_o <= 3'h0;
            slot_o <= 1'b0;
            oe_o <= 1'b0;
        end
        else
        begin
            tick <= tick + 4'h1;
            if (go_i)
                act_o <= 1'b1;
            if (act_o && !oe_o && tick == 4'h0 && !busy_w_i)
                lvl_o <= lvl_i;
            if (tick == 4'h5)
            begin
                slot_o <= (lvl_o != 3'h0) && ({1'b0, lvl_w_i} < {lvl_o, 1'b0});
                lvl_o <= 3'h0;
            end
            // Slot zero is always the lowest driver, so surviving means winning.
            if (tick == 4'hA && slot_o)
            begin
                oe_o <= 1'b1;
                slot_o <= 1'b0;
                n <= 8'h00;
                ph <= 2'h1;
            end
            if (oe_o)
            begin
                ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
                if (ph == 2'h0 && n <= len_i)
                begin
                    strb_o <= 1'b1;
                    sof_o <= (n == 8'h00);
                    data_o <= (n == 8'h00) ? {typ_i, len_i} : {typ_i, n - 8'h01};
                    n <= n + 8'h01;
                end
                else if (ph == 2'h0)
                begin
                    oe_o <= 1'b0;
                    act_o <= 1'b0;
                end
            end
        end
    end
endmodule

// ---- sim/bbmi_tb_top.sv ----
`timescale 1ns/1ps
module bbmi_tb_top;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] card_slot_i = 3'h3;
    logic [15:0] bus_data_i, bus_data_o, cpu_wdata_i, cpu_rdata_o, sram_wdata_o, sram_rdata_i;
    logic [15:0] p_data, idle_pat;
    logic bus_data_oe_o, bus_strb_i, bus_strb_o, bus_sof_i, bus_sof_o;
    logic bus_busy_i, bus_busy_o, bus_busy_oe_o, tune_we_i, tune_fifo_i, tune_valid_i;
    logic cpu_req_i, cpu_wr_i, cpu_sel_i, cpu_ack_o, cpu_err_o, sram_we_o, sram_ce_o;
    logic rx_drop_o, p_go, p_oe, p_strb, p_sof, p_slot, p_act;
    logic [2:0] bus_lvl_i, bus_lvl_o, bus_lvl_oe_o, p_lvl, p_want;
    logic [7:0] bus_slot_i, bus_slot_o, bus_slot_oe_o, tune_type_i, p_typ, p_len;
    logic [3:0] tune_idx_i, fifo_empty_o, fifo_full_o;
    logic [1:0] tx_prio0_i, tx_prio1_i;
    logic [11:0] sram_addr_o;
    logic [15:0] mem [0:4095];
    logic [15:0] bus_q[$], msg[$];
    logic [17:0] cpu_q[$];
    logic [17:0] ent;
    logic [15:0] got_w;
    logic [1:0] dprio [3] = '{2'h1, 2'h2, 2'h3};
    logic [2:0] plvl [3] = '{3'b100, 3'b001, 3'b100};
    logic pfirst [3] = '{1'b1, 1'b0, 1'b1};
    int miscompares = 0;
    int n_checks = 0;

    always #20 ref_clk_i = ~ref_clk_i;
    bbmi_top DUT (.*);
    bbmi_peer u_peer (.clk_i(ref_clk_i), .rst_i(sys_rst_i), .go_i(p_go), .typ_i(p_typ),
        .len_i(p_len), .lvl_i(p_want), .busy_w_i(bus_busy_i), .lvl_w_i(bus_lvl_i),
        .data_o(p_data), .oe_o(p_oe), .strb_o(p_strb), .sof_o(p_sof), .lvl_o(p_lvl),
        .slot_o(p_slot), .act_o(p_act));

    // ----
    // Shared bus wires and external memory.
    // ----
    // Wired-OR lines; an undriven data bus shows a changing pattern, not old data.
    assign bus_strb_i = (bus_strb_o & bus_data_oe_o) | p_strb;
    assign bus_sof_i = (bus_sof_o & bus_data_oe_o) | p_sof;
    assign bus_busy_i = (bus_busy_o & bus_busy_oe_o) | p_oe;
    assign bus_lvl_i = (bus_lvl_o & bus_lvl_oe_o) | p_lvl;
    assign bus_slot_i = (bus_slot_o & bus_slot_oe_o) | {7'h00, p_slot};
    assign bus_data_i = bus_data_oe_o ? bus_data_o : (p_oe ? p_data : idle_pat);
    assign sram_rdata_i = mem[sram_addr_o];
    // The memory writes on the edge that ends an enabled write cycle.
    always @(posedge ref_clk_i)
    begin
        idle_pat <= ~idle_pat;
        if (sram_ce_o && sram_we_o)
            mem[sram_addr_o] <= sram_wdata_o;
    end

    // ----
    // Comparisons and stimulus tasks.
    // ----
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Each bus strobe and each acknowledge takes the oldest note.
    always @(posedge ref_clk_i)
    begin
        if (!sys_rst_i && bus_strb_i === 1'b1)
        begin
            got_w = bus_q.size() ? bus_q.pop_front() : 16'hXXXX;
            chk_word(bus_data_i, got_w);
        end
        if (cpu_ack_o === 1'b1)
        begin
            ent = cpu_q.size() ? cpu_q.pop_front() : 18'h3FFFF;
            chk_resp({cpu_err_o, (ent[17] | ent[16]) ? 16'h0000 : cpu_rdata_o}, ent[16:0]);
        end
    end
    task automatic step;
        @(posedge ref_clk_i);
        #1;
    endtask
    // The request stays up until the edge that ends the acknowledge cycle.
    task automatic cpu_op(input logic wr, input logic sel, input logic [15:0] wd,
        input logic [16:0] exp);
        int i;
        cpu_q.push_back({wr, exp});
        step();
        cpu_req_i = 1'b1;
        cpu_wr_i = wr;
        cpu_sel_i = sel;
        cpu_wdata_i = wd;
        for (i = 0; i < 60 && cpu_ack_o !== 1'b1; i++)
            step();
        step();
        cpu_req_i = 1'b0;
    endtask
    task automatic tune(input logic [3:0] idx, input logic [7:0] typ, input logic q);
        step();
        tune_we_i = 1'b1;
        tune_idx_i = idx;
        tune_type_i = typ;
        tune_fifo_i = q;
        tune_valid_i = 1'b1;
        step();
        tune_we_i = 1'b0;
    endtask
    task automatic peer_msg(input logic [7:0] typ, input logic [7:0] len, input logic [2:0] lvl);
        p_typ = typ;
        p_len = len;
        p_want = lvl;
        p_go = 1'b1;
        step();
        p_go = 1'b0;
    endtask
    task automatic tx_fill(input logic sel, input logic [7:0] typ, input logic [7:0] len);
        int k;
        msg.delete();
        msg.push_back({typ, len});
        for (k = 0; k < len; k++)
            msg.push_back(16'($urandom));
        foreach (msg[j])
            cpu_op(1'b1, sel, msg[j], 17'h00000);
    endtask
    task automatic rd_back(input logic sel);
        foreach (msg[j])
            cpu_op(1'b0, sel, 16'h0000, {1'b0, msg[j]});
        cpu_op(1'b0, sel, 16'h0000, 17'h10000);
    endtask
    task automatic wait_idle;
        int i;
        i = 0;
        while (i < 3000 && (bus_busy_i || p_act || fifo_empty_o[3:2] != 2'b11))
        begin
            step();
            i++;
        end
        if (i == 3000)
            miscompares++;
        repeat (8) step();
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----
    // Main sequence and watchdog.
    // ----
    initial
    begin
        {tune_we_i, tune_fifo_i, tune_valid_i, cpu_req_i, cpu_wr_i, cpu_sel_i, p_go} = 7'h00;
        {tune_idx_i, tune_type_i, tx_prio0_i, tx_prio1_i, p_want} = 19'h00000;
        {cpu_wdata_i, p_typ, p_len} = 32'h00000000;
        idle_pat = 16'hA5C3;
        void'($urandom(38425));
        repeat (12) @(posedge ref_clk_i);
        #1;
        sys_rst_i = 1'b0;
        chk_resp({bus_busy_o, 12'h000, fifo_empty_o}, {1'b0, 12'h000, 4'hF});
        tune(4'h0, 8'h5A, 1'b0);
        tune(4'h1, 8'h77, 1'b1);
        bus_q = {bus_q, 16'h3301, 16'h3300, 16'h5A02, 16'h5A00, 16'h5A01};
        peer_msg(8'h33, 8'h01, 3'b010);
        wait_idle();
        peer_msg(8'h5A, 8'h02, 3'b001);
        wait_idle();
        msg = {16'h5A02, 16'h5A00, 16'h5A01};
        rd_back(1'b0);
        tx_fill(1'b0, 8'h77, 8'h03);
        bus_q = {bus_q, msg};
        tx_prio0_i = 2'h3;
        wait_idle();
        tx_prio0_i = 2'h0;
        rd_back(1'b1);
        // Low, mean and an equal high level against the card in slot zero.
        for (int c = 0; c < 3; c++)
        begin
            tx_fill(1'b1, 8'h66, 8'h01);
            bus_q = pfirst[c] ? {bus_q, 16'h4101, 16'h4100, msg} : {bus_q, msg, 16'h4101, 16'h4100};
            // The peer is armed first so that both cards enter the same round.
            peer_msg(8'h41, 8'h01, plvl[c]);
            tx_prio1_i = dprio[c];
            wait_idle();
            tx_prio1_i = 2'h0;
        end
        chk_word(16'(bus_q.size() + cpu_q.size()), 16'h0000);
        chk_word({7'h00, rx_drop_o, fifo_full_o, fifo_empty_o}, 16'h000F);
        complete_run();
    end
    initial
    begin
        #2000000;
        miscompares++;
        complete_run();
    end
endmodule
